// >>> design/flash_pwr_cfg.svh
// Timing and encoding constants for the flash power and reset controller
`ifndef FLASH_PWR_CFG_SVH
`define FLASH_PWR_CFG_SVH
`define CLK_PERIOD_PS      8000
`define RST_ERASE_MAX_NS   20000
`define RST_PROG_MAX_NS    10000
`define RST_READ_MIN_NS    100
`define ABORT_CNT_W        16
`define CMD_W              8
`define CMD_READ_ARRAY     8'hFF
`define CMD_PROG_SETUP     8'h40
`define CMD_ERASE_SETUP    8'h20
`define CMD_CONFIRM        8'hD0
`define CMD_SET_BURST      8'h60
`define CMD_BURST_CONFIRM  8'h03
`endif

// >>> design/flash_pwr_pkg.sv
// Types shared by the flash power and reset controller
package flash_pwr_pkg;
   typedef enum logic [1:0] {
      PWR_RESET   = 2'b00,
      PWR_STANDBY = 2'b01,
      PWR_ACTIVE  = 2'b10,
      PWR_IDLE    = 2'b11
   } pwr_state_t;
   typedef enum logic [1:0] {
      CMD_IDLE    = 2'b00,
      CMD_PROG    = 2'b01,
      CMD_ERASE   = 2'b10,
      CMD_BURST   = 2'b11
   } cmd_phase_t;
endpackage

// >>> design/abort_timer.sv
// Down counter that times the abort of an operation cut short by reset
`timescale 1ns/1ps
`include "flash_pwr_cfg.svh"
module abort_timer #(
   parameter int CNT_W = `ABORT_CNT_W
) (
   input  wire logic             sys_clk_i,
   input  wire logic             srst_i,
   input  wire logic             load_i,   // Start a new countdown
   input  wire logic [CNT_W-1:0] count_i,  // Cycles to count
   output logic                  busy_o    // Countdown running
);
   logic [CNT_W-1:0] cnt_ff;      // Remaining cycles
   logic [CNT_W-1:0] nxt_cnt;

   // Next count: load, else count down to zero
   always_comb begin
      nxt_cnt = cnt_ff;
      if (load_i) begin
         nxt_cnt = count_i;
      end else if (cnt_ff != '0) begin
         nxt_cnt = cnt_ff - CNT_W'(1);
      end
   end

   // Register the count
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   assign busy_o = (cnt_ff != '0);
endmodule

// >>> design/flash_power_reset_mode_control.sv
// Power mode, reset and command write protection control of a parallel flash
//
// Overview of operation
// - Selected and out of reset means active
// - Selected, idle, static address enters auto idle
// - Chip select high enters standby
// - Standby floats data outputs regardless of OE
// - Deselected program or erase runs to completion
// - Command write needs write enable and select low
// - Memory altered only after two step command
// - Reset low ignores all control inputs
// - Latched command immune to select and engine
// - Reset exit or supply valid gives read array
// - Read array after reset uses asynchronous reads
// - Reset aborts erase within 20 us
// - Reset aborts program within 10 us
`timescale 1ns/1ps
`include "flash_pwr_cfg.svh"
module flash_power_reset_mode_control
   import flash_pwr_pkg::*;
#(
   parameter int ADDR_W        = 22,
   parameter int ERASE_ABORT_C = (`RST_ERASE_MAX_NS * 1000) / `CLK_PERIOD_PS,
   parameter int PROG_ABORT_C  = (`RST_PROG_MAX_NS * 1000) / `CLK_PERIOD_PS
) (
   input  wire logic              sys_clk_i,
   input  wire logic              srst_i,
   input  wire logic              rst_n_i,        // Device reset pin, low = reset
   input  wire logic              supply_ok_i,    // Core supply above supply_lockout_threshold
   input  wire logic              ce_n_i,         // Chip select, low = selected
   input  wire logic              we_n_i,         // Write enable, low = write
   input  wire logic              oe_n_i,         // Output enable, low = drive
   input  wire logic [ADDR_W-1:0] addr_i,         // Address inputs
   input  wire logic [`CMD_W-1:0] cmd_data_i,     // Command byte on the data bus
   input  wire logic              op_done_i,      // Write engine finished operation
   input  wire logic              read_busy_i,    // Internal read sensing in progress
   output logic [1:0]             pwr_state_o,    // Current power mode
   output logic                   data_oe_n_o,    // Data bus enable, low = drive
   output logic                   prog_start_o,   // Pulse: start program
   output logic                   erase_start_o,  // Pulse: start erase
   output logic                   op_abort_o,     // Abort running operation
   output logic                   engine_busy_o,  // Program or erase in progress
   output logic                   read_array_o,   // Command interface in read array
   output logic                   sync_burst_o,   // Synchronous burst reads enabled
   output logic                   ready_o         // Device out of reset and idle of abort
);
   // Refuse parameters that the abort counter cannot hold
   if (ADDR_W < 1 || ERASE_ABORT_C < 1 || PROG_ABORT_C < 1 ||
       ERASE_ABORT_C >= (1 << `ABORT_CNT_W) || PROG_ABORT_C >= (1 << `ABORT_CNT_W)) begin
      $error("flash_power_reset_mode_control: unsupported parameters");
   end

   // Registered state
   pwr_state_t        pwr_ff, nxt_pwr;           // Power mode
   cmd_phase_t        phase_ff, nxt_phase;       // Two step command progress
   logic              busy_ff, nxt_busy;         // Engine operation running
   logic              is_erase_ff, nxt_is_erase; // Running operation is an erase
   logic              rdarr_ff, nxt_rdarr;       // Read array mode
   logic              burst_ff, nxt_burst;       // Synchronous burst configured
   logic              we_n_ff, nxt_we_n;         // Previous write strobe
   logic [ADDR_W-1:0] addr_ff, nxt_addr;         // Previous address
   logic              prog_ff, nxt_prog;         // Program start pulse
   logic              erase_ff, nxt_erase;       // Erase start pulse
   logic              oe_ff, nxt_oe;             // Data output enable, low = drive

   // Combinational helpers
   logic              in_reset;        // Device held in reset
   logic              wr_strobe;       // Completed command write
   logic              abort_load;      // Start abort countdown
   logic [`ABORT_CNT_W-1:0] abort_cnt; // Abort duration in cycles
   logic              abort_busy;      // Abort still in progress

   function automatic logic is_cmd(input logic [`CMD_W-1:0] d, input logic [`CMD_W-1:0] c);
      return d == c;
   endfunction

   // Reset pin low or supply below lockout disables the device
   assign in_reset  = !rst_n_i || !supply_ok_i;
   // Write taken at rising write edge while select low
   assign wr_strobe = !in_reset && !ce_n_i && we_n_i && !we_n_ff;
   // Aborts start on entering reset with an operation running
   assign abort_load = in_reset && busy_ff;
   assign abort_cnt  = is_erase_ff ? `ABORT_CNT_W'(ERASE_ABORT_C)
                                   : `ABORT_CNT_W'(PROG_ABORT_C);

   abort_timer #(
      .CNT_W (`ABORT_CNT_W)
   ) u_abort (
      .sys_clk_i (sys_clk_i),
      .srst_i    (srst_i),
      .load_i    (abort_load),
      .count_i   (abort_cnt),
      .busy_o    (abort_busy)
   );

   // Command interface and engine tracking next values
   always_comb begin
      nxt_phase    = phase_ff;
      nxt_busy     = busy_ff;
      nxt_is_erase = is_erase_ff;
      nxt_rdarr    = rdarr_ff;
      nxt_burst    = burst_ff;
      nxt_prog     = 1'b0;
      nxt_erase    = 1'b0;
      nxt_we_n     = we_n_i;
      if (in_reset) begin
         // Reset discards commands and aborts any operation
         nxt_phase = CMD_IDLE;
         nxt_busy  = 1'b0;
         nxt_rdarr = 1'b1;
         nxt_burst = 1'b0;
         nxt_we_n  = 1'b1;
      end else begin
         // Completion leaves read mode unchanged
         if (busy_ff && op_done_i) begin
            nxt_busy = 1'b0;
         end
         // Only write strobes alter the latched command
         if (wr_strobe) begin
            case (phase_ff)
               CMD_IDLE: begin
                  if (is_cmd(cmd_data_i, `CMD_READ_ARRAY)) begin
                     nxt_rdarr = 1'b1;
                  end else if (is_cmd(cmd_data_i, `CMD_PROG_SETUP)) begin
                     nxt_phase = CMD_PROG;
                     nxt_rdarr = 1'b0;
                  end else if (is_cmd(cmd_data_i, `CMD_ERASE_SETUP)) begin
                     nxt_phase = CMD_ERASE;
                     nxt_rdarr = 1'b0;
                  end else if (is_cmd(cmd_data_i, `CMD_SET_BURST)) begin
                     nxt_phase = CMD_BURST;
                  end
               end
               CMD_PROG: begin
                  // Second cycle carries the data; program only if idle
                  nxt_phase = CMD_IDLE;
                  if (!busy_ff) begin
                     nxt_prog     = 1'b1;
                     nxt_busy     = 1'b1;
                     nxt_is_erase = 1'b0;
                  end
               end
               CMD_ERASE: begin
                  nxt_phase = CMD_IDLE;
                  if (is_cmd(cmd_data_i, `CMD_CONFIRM) && !busy_ff) begin
                     nxt_erase    = 1'b1;
                     nxt_busy     = 1'b1;
                     nxt_is_erase = 1'b1;
                  end
               end
               CMD_BURST: begin
                  nxt_phase = CMD_IDLE;
                  if (is_cmd(cmd_data_i, `CMD_BURST_CONFIRM)) begin
                     nxt_burst = 1'b1;
                  end
               end
               default: begin
                  nxt_phase = CMD_IDLE;
               end
            endcase
         end
      end
   end

   // Power mode next value
   always_comb begin
      nxt_addr = addr_i;
      nxt_oe   = 1'b1;
      nxt_pwr  = pwr_ff;
      if (in_reset) begin
         nxt_pwr = PWR_RESET;
      end else if (ce_n_i) begin
         // Deselected: engine work keeps active power
         nxt_pwr = (busy_ff || prog_ff || erase_ff) ? PWR_ACTIVE : PWR_STANDBY;
      end else if (addr_i != addr_ff || prog_ff || erase_ff || read_busy_i) begin
         nxt_pwr = PWR_ACTIVE;
      end else if (!busy_ff) begin
         nxt_pwr = PWR_IDLE;
      end else begin
         nxt_pwr = PWR_ACTIVE;
      end
      // Outputs driven only when selected, out of reset, OE low, no write
      if (!in_reset && !ce_n_i && !oe_n_i && we_n_i) begin
         nxt_oe = 1'b0;
      end else begin
         nxt_oe = 1'b1;
      end
   end

   // Register all state
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         pwr_ff      <= PWR_RESET;
         phase_ff    <= CMD_IDLE;
         busy_ff     <= 1'b0;
         is_erase_ff <= 1'b0;
         rdarr_ff    <= 1'b1;
         burst_ff    <= 1'b0;
         we_n_ff     <= 1'b1;
         addr_ff     <= '0;
         prog_ff     <= 1'b0;
         erase_ff    <= 1'b0;
         oe_ff       <= 1'b1;
      end else begin
         pwr_ff      <= nxt_pwr;
         phase_ff    <= nxt_phase;
         busy_ff     <= nxt_busy;
         is_erase_ff <= nxt_is_erase;
         rdarr_ff    <= nxt_rdarr;
         burst_ff    <= nxt_burst;
         we_n_ff     <= nxt_we_n;
         addr_ff     <= nxt_addr;
         prog_ff     <= nxt_prog;
         erase_ff    <= nxt_erase;
         oe_ff       <= nxt_oe;
      end
   end

   // Outputs
   assign pwr_state_o   = pwr_ff;
   assign data_oe_n_o   = oe_ff;
   assign prog_start_o  = prog_ff;
   assign erase_start_o = erase_ff;
   assign op_abort_o    = abort_busy;
   assign engine_busy_o = busy_ff;
   assign read_array_o  = rdarr_ff;
   assign sync_burst_o  = burst_ff;
   assign ready_o       = (pwr_ff != PWR_RESET) && !abort_busy;
endmodule

// >>> verification/flash_pwr_checker_assertions.sv
// Port level checks of the flash power and reset controller
`timescale 1ns/1ps
module flash_pwr_checker #(
   parameter int ADDR_W        = 22,
   parameter int ERASE_ABORT_C = 2500,
   parameter int PROG_ABORT_C  = 1250
) (
   input wire logic              sys_clk_i,
   input wire logic              srst_i,
   input wire logic              rst_n_i,
   input wire logic              supply_ok_i,
   input wire logic              ce_n_i,
   input wire logic              we_n_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic              op_done_i,
   input wire logic [1:0]        pwr_state_o,
   input wire logic              data_oe_n_o,
   input wire logic              prog_start_o,
   input wire logic              erase_start_o,
   input wire logic              op_abort_o,
   input wire logic              engine_busy_o,
   input wire logic              read_array_o
);
   int   abort_run_ff;  // Cycles the abort has run
   int   nxt_abort_run;
   logic last_prog_ff;  // Last started operation was a program
   logic nxt_last_prog;
   // Abort span and kind of the last started operation
   always_comb begin
      nxt_abort_run = op_abort_o ? abort_run_ff + 1 : 0;
      nxt_last_prog = prog_start_o | (last_prog_ff & ~erase_start_o);
   end
   always_ff @(posedge sys_clk_i) begin
      abort_run_ff <= srst_i ? 0 : nxt_abort_run;
      last_prog_ff <= srst_i ? 1'b0 : nxt_last_prog;
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);
   AST_STANDBY: assert property ((ce_n_i && rst_n_i && supply_ok_i && !engine_busy_o
      && !op_abort_o) |=> pwr_state_o == 2'h1) else $error("standby not entered");
   AST_HIGHZ: assert property (pwr_state_o == 2'h1 |-> data_oe_n_o)
      else $error("data driven in standby");
   AST_DESEL_BUSY: assert property ((ce_n_i && engine_busy_o && !op_done_i && rst_n_i
      && supply_ok_i) |=> pwr_state_o == 2'h2) else $error("busy deselect not active");
   AST_ADDR_WAKE: assert property ((!ce_n_i && rst_n_i && supply_ok_i && !op_abort_o
      && addr_i != $past(addr_i)) |=> pwr_state_o == 2'h2) else $error("no wake on address");
   AST_RESET: assert property (!rst_n_i |=> pwr_state_o == 2'h0 && !engine_busy_o
      && read_array_o && !prog_start_o && !erase_start_o) else $error("reset not obeyed");
   AST_WRITE_GATE: assert property (($rose(prog_start_o) || $rose(erase_start_o))
      |-> !$past(ce_n_i) && $past(we_n_i) && !$past(we_n_i, 2)) else $error("bad write");
   AST_START_PULSE: assert property ((prog_start_o || erase_start_o)
      |=> !prog_start_o && !erase_start_o) else $error("start longer than a cycle");
   AST_ABORT_LEN: assert property (op_abort_o
      |-> abort_run_ff < (last_prog_ff ? PROG_ABORT_C : ERASE_ABORT_C))
      else $error("abort too long");
   AST_ABORT_CAUSE: assert property ($rose(op_abort_o) |-> !$past(rst_n_i)
      || !$past(rst_n_i, 2) || !$past(supply_ok_i) || !$past(supply_ok_i, 2))
      else $error("abort without reset");
endmodule
bind flash_power_reset_mode_control flash_pwr_checker #(.ADDR_W(ADDR_W),
   .ERASE_ABORT_C(ERASE_ABORT_C), .PROG_ABORT_C(PROG_ABORT_C)) i_chk (.sys_clk_i,
   .srst_i, .rst_n_i, .supply_ok_i, .ce_n_i, .we_n_i, .addr_i, .op_done_i, .pwr_state_o,
   .data_oe_n_o, .prog_start_o, .erase_start_o, .op_abort_o, .engine_busy_o, .read_array_o);

// >>> verification/flash_host_model.sv
// Host model driving the flash control pins
`timescale 1ns/1ps
module flash_host_model (
   input  wire logic sys_clk_i,
   output logic      rst_n_o,
   output logic      ce_n_o,
   output logic      we_n_o,
   output logic      oe_n_o,
   output logic [21:0] addr_o,
   output logic [7:0]  cmd_o
);
   // Held in reset after supply comes up
   initial begin
      {rst_n_o, ce_n_o, we_n_o, oe_n_o} = 4'h7;
      addr_o = 22'h0;
      cmd_o = 8'h00;
   end
   // Reset stays low long after supply valid
   task power_up();
      repeat (7500) @(posedge sys_clk_i);
      rst_n_o <= 1'b1;
   endtask
   // Reset pulse of n cycles, 13 covers the minimum
   task rst_pulse(input int n);
      @(posedge sys_clk_i);
      rst_n_o <= 1'b0;
      repeat (n) @(posedge sys_clk_i);
      rst_n_o <= 1'b1;
   endtask
   // Select, output enable and address
   task pins(input logic sel_n, input logic out_n, input logic [21:0] a);
      @(posedge sys_clk_i);
      ce_n_o <= sel_n;
      oe_n_o <= out_n;
      addr_o <= a;
   endtask
   // Command write, select and data held across the rising write edge
   task wr(input logic [7:0] d, input logic sel_n);
      @(posedge sys_clk_i);
      {ce_n_o, we_n_o, cmd_o} <= {sel_n, 1'b0, d};
      @(posedge sys_clk_i);
      we_n_o <= 1'b1;
      @(posedge sys_clk_i);
      ce_n_o <= 1'b1;
      cmd_o <= ~d; // Released bus shows no stale value
   endtask
endmodule

// >>> verification/flash_power_reset_mode_control_tb.sv
// Self-checking bench for the flash power and reset controller
`timescale 1ns/1ps
module flash_power_reset_mode_control_tb;
   import flash_pwr_pkg::*;
   logic sys_clk_i, srst_i, supply_ok_i, op_done_i, read_busy_i;
   logic rst_n, ce_n, we_n, oe_n, doe_n, ps, es, ab, busy, ra, sb, rdy;
   logic [21:0] addr;
   logic [7:0]  cmd;
   logic [1:0]  pwr;
   int err_total, total_checks, erase_cnt, prog_cnt, abort_cyc;
   flash_host_model i_host (.sys_clk_i(sys_clk_i), .rst_n_o(rst_n), .ce_n_o(ce_n),
      .we_n_o(we_n), .oe_n_o(oe_n), .addr_o(addr), .cmd_o(cmd));
   flash_power_reset_mode_control #(.ADDR_W(22), .ERASE_ABORT_C(20), .PROG_ABORT_C(10))
   i_dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .rst_n_i(rst_n), .supply_ok_i(supply_ok_i),
      .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .addr_i(addr), .cmd_data_i(cmd),
      .op_done_i(op_done_i), .read_busy_i(read_busy_i), .pwr_state_o(pwr),
      .data_oe_n_o(doe_n), .prog_start_o(ps), .erase_start_o(es), .op_abort_o(ab),
      .engine_busy_o(busy), .read_array_o(ra), .sync_burst_o(sb), .ready_o(rdy));
   // Clock and event counters
   initial begin
      sys_clk_i = 1'b0;
      forever #4 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      erase_cnt += (es === 1'b1);
      prog_cnt += (ps === 1'b1);
      abort_cyc += (ab === 1'b1);
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %0t got %0h exp %0h", $time, g, e);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   task summarize();
      if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Standby, auto idle, read sensing and wake on address
   task t_modes();
      i_host.pins(1'b1, 1'b0, 22'h0);
      tick(2);
      chk(pwr, 2'h1);
      chk(doe_n, 1'b1);
      i_host.pins(1'b0, 1'b0, 22'h0);
      tick(3);
      chk(pwr, 2'h3);
      chk(doe_n, 1'b0);
      i_host.pins(1'b0, 1'b0, 22'h2A5);
      tick(1);
      chk(pwr, 2'h2);
      @(posedge sys_clk_i) read_busy_i <= 1'b1;
      tick(2);
      chk(pwr, 2'h2);
      @(posedge sys_clk_i) read_busy_i <= 1'b0;
      tick(2);
      chk(pwr, 2'h3);
   endtask
   // Refused write then erase aborted by reset
   task t_erase();
      i_host.wr(8'h20, 1'b1);
      i_host.wr(8'hD0, 1'b0);
      tick(3);
      chk(erase_cnt, 0);
      i_host.wr(8'h20, 1'b0);
      i_host.wr(8'hD0, 1'b0);
      tick(3);
      chk({erase_cnt[3:0], busy, ra, pwr}, 8'h1A);
      abort_cyc = 0;
      i_host.rst_pulse(13);
      tick(40);
      chk(abort_cyc, 20);
      chk({ra, busy}, 2'h2);
      chk(rdy, 1'b1);
   endtask
   // Program, read mode, burst set-up and program abort
   task t_prog();
      i_host.wr(8'h40, 1'b0);
      i_host.wr(8'h5A, 1'b0);
      @(posedge sys_clk_i) op_done_i <= 1'b1;
      @(posedge sys_clk_i) op_done_i <= 1'b0;
      tick(2);
      chk({prog_cnt[3:0], busy, ra}, 6'h04);
      i_host.wr(8'hFF, 1'b0);
      i_host.wr(8'h60, 1'b0);
      i_host.wr(8'h03, 1'b0);
      tick(2);
      chk({ra, sb}, 2'h3);
      i_host.wr(8'h40, 1'b0);
      i_host.wr(8'h11, 1'b0);
      abort_cyc = 0;
      i_host.rst_pulse(13);
      tick(30);
      chk({abort_cyc[7:0], sb}, 9'h014);
      @(posedge sys_clk_i) supply_ok_i <= 1'b0;
      tick(2);
      chk({pwr, ra}, 3'h1);
      chk(rdy, 1'b0);
   endtask
   initial begin
      {srst_i, supply_ok_i, op_done_i, read_busy_i} = 4'hC;
      repeat (3) @(posedge sys_clk_i);
      srst_i <= 1'b0;
      i_host.power_up();
      tick(2);
      chk({ra, sb}, 2'h2);
      t_modes();
      t_erase();
      t_prog();
      summarize();
   end
   initial begin
      #200000;
      err_total++;
      summarize();
   end
endmodule
